/* File: rtl/dscc_map.vh */
// Constants for the serial command control block of the 12-bit converter.
`ifndef DSCC_MAP_VH
`define DSCC_MAP_VH
`define DSCC_WORD_BITS 16
`define DSCC_DATA_BITS 12
`define DSCC_CMD_HI 15
`define DSCC_CMD_LO 13
`define DSCC_DATA_HI 12
`define DSCC_DATA_LO 1
`define DSCC_MODE_BIT 12
`define DSCC_MODE0_BIT 11
`define DSCC_CMD_NOP 3'h0
`define DSCC_CMD_LOAD_IN 3'h1
`define DSCC_CMD_LOAD_BOTH 3'h2
`define DSCC_CMD_UPDATE 3'h3
`define DSCC_CMD_UPO_LOW 3'h4
`define DSCC_CMD_SHDN 3'h5
`define DSCC_CMD_UPO_HIGH 3'h6
`define DSCC_CMD_MODE 3'h7
`define DSCC_MIDSCALE 12'h800
`define DSCC_ZERO 12'h000
`define DSCC_WORD_ZERO 16'h0000
`define DSCC_INIT_START 2'h0
`define DSCC_INIT_DONE 2'h3
`endif

/* File: rtl/dscc_sync.v */
// Two-stage synchroniser for a group of pin-level inputs.
`timescale 1ns/100ps
module dscc_sync
#(
  parameter WIDTH = 1
)
(
  input wire core_clk,
  input wire rst,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // The first stage feeds only the second, so no logic sees a metastable level.
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

/* File: rtl/dscc_top.v */
// Serial command decoder, double-buffered data registers and shutdown control.
// Timing and hazards
// Every pin passes the two-stage synchroniser, so the core sees each pin
// event two clocks late and acts on it one clock after that.
// A command therefore lands three core clocks after chip select rises.
// The shift clock must stay at each level for at least three core clocks,
// or an edge can slip between the synchroniser stages and be lost.
// Chip select must stay high for at least three core clocks between words.
// More than sixteen rising shift edges in one frame keep the last sixteen,
// which is what lets several converters share one chained data line.
// The command is decoded from the register as it stands when chip select
// rises, so a frame cut short decodes whatever bits it happens to hold.
// The lockout wake and the clear input pass the same synchroniser as the
// other pins, so they act a few core clocks late and not truly at once.
// This costs nothing in practice, because the core clock never stops.
// The power-down pin acts on its rising level change while lockout is high.
// Holding it high after a command wake does not put the block back to sleep;
// the pin must be lowered and raised again for a new shutdown request.
// A low lockout input blocks every entry into shutdown, but it only wakes
// the block through its falling edge, never through its level.
// Clear held low keeps the converter code at the reset value on every clock
// and keeps the block awake for as long as it is held.
// A clear seen during shutdown remembers that the user output must fall,
// and the output falls on the first clock after the block is awake again.
// The output enable follows the next shutdown value, so it and the shutdown
// flag always change on the same clock edge.
// Settling of the reference after a wake is left to the controller.
// After reset the synchroniser shows its reset level for two clocks, so
// the power-up codes are loaded on three clocks in a row; only the last
// load sees the real select pin, and the loads hide the false chip select
// edge that the synchroniser makes as it comes out of reset.
// Data out is fed only from the top bit of the shift register, on the edge
// the mode selects, so it keeps its level during shutdown by itself.
// In the rising-edge mode the bit launched on the last rising edge of a
// word is the sub-bit of the word before, half a cycle later than in the
// falling-edge mode.
// The clear input does not touch the input register, so a later update
// command brings back the code that was last loaded there.
`timescale 1ns/100ps
`include "dscc_map.vh"
module dscc_top
(
  input wire core_clk,
  input wire rst,
  input wire chip_select_n,
  input wire shift_clk,
  input wire serial_in,
  input wire reset_value_select,
  input wire powerdown_lockout,
  input wire clear_n,
  input wire powerdown_pin,
  output reg serial_out,
  output reg user_output_pin,
  output reg [11:0] dac_code,
  output reg [11:0] input_code,
  output reg shutdown,
  output reg analog_out_en,
  output reg rising_mode
);

  wire [5:0] pins_sync;
  wire cs_n_s;
  wire sclk_s;
  wire sdi_s;
  wire reset_value_select_s;
  wire pdl_s;
  wire clr_n_s;
  wire pd_s;
  reg sclk_d_r;
  reg cs_n_d_r;
  reg pdl_d_r;
  reg clr_n_d_r;
  reg reset_value_select_d_r;
  reg pd_d_r;
  reg [15:0] shift_r;
  reg [15:0] shift_nxt;
  reg [11:0] input_nxt;
  reg [11:0] dac_nxt;
  reg shdn_nxt;
  reg upo_nxt;
  reg mode_nxt;
  reg sdo_nxt;
  reg upo_reset_pending_r;
  reg upo_reset_pending_nxt;
  reg [1:0] init_cnt_r;
  wire init_busy;
  wire sclk_rise;
  wire sclk_fall;
  wire cs_rise;
  wire pdl_fall;
  wire [2:0] cmd;
  wire [11:0] sample;
  wire [11:0] reset_code;

  // Reset code chosen by the select pin, shared by power-up and clear.
  function [11:0] dscc_reset_code;
    input sel;
    begin
      dscc_reset_code = sel ? `DSCC_MIDSCALE : `DSCC_ZERO;
    end
  endfunction

  // Rising edge of a synchronised level against its delayed copy.
  function dscc_rise;
    input cur;
    input prev;
    begin
      dscc_rise = cur & ~prev;
    end
  endfunction

  // Falling edge of a synchronised level against its delayed copy.
  function dscc_fall;
    input cur;
    input prev;
    begin
      dscc_fall = ~cur & prev;
    end
  endfunction

  // All pin inputs come from another domain, so each passes two flops.
  dscc_sync #(.WIDTH(7)) u_sync
  (
    .core_clk(core_clk),
    .rst(rst),
    .async_in({chip_select_n, shift_clk, serial_in, reset_value_select,
               powerdown_lockout, clear_n, powerdown_pin}),
    .sync_out({cs_n_s, pins_sync})
  );

  assign sclk_s = pins_sync[5];
  assign sdi_s = pins_sync[4];
  assign reset_value_select_s = pins_sync[3];
  assign pdl_s = pins_sync[2];
  assign clr_n_s = pins_sync[1];
  assign pd_s = pins_sync[0];

  // Edge detection on the synchronised copies only.
  // A false chip select edge just after reset falls inside the power-up
  // loads, which skip all command decoding, so it does no harm.
  assign sclk_rise = dscc_rise(sclk_s, sclk_d_r);
  assign sclk_fall = dscc_fall(sclk_s, sclk_d_r);
  assign cs_rise = dscc_rise(cs_n_s, cs_n_d_r);
  assign pdl_fall = dscc_fall(pdl_s, pdl_d_r);

  // Power-up loads run until the select pin has crossed the synchroniser.
  assign init_busy = (init_cnt_r != `DSCC_INIT_DONE);

  // Word fields: command on top, sample bits, then the sub-bit at bit 0.
  assign cmd = shift_r[`DSCC_CMD_HI:`DSCC_CMD_LO];
  assign sample = shift_r[`DSCC_DATA_HI:`DSCC_DATA_LO];
  assign reset_code = dscc_reset_code(reset_value_select_s);

  // Next-state logic for the shift register, data registers and modes.
  always @*
  begin
    shift_nxt = shift_r;
    input_nxt = input_code;
    dac_nxt = dac_code;
    shdn_nxt = shutdown;
    upo_nxt = user_output_pin;
    mode_nxt = rising_mode;
    sdo_nxt = serial_out;
    upo_reset_pending_nxt = upo_reset_pending_r;
    if (init_busy)
    begin
      // The last of these loads sees the select pin through the synchroniser.
      input_nxt = reset_code;
      dac_nxt = reset_code;
    end
    else
    begin
      if (sclk_rise && !cs_n_s)
      begin
        shift_nxt = {shift_r[14:0], sdi_s};
      end
      // Data out shows the register MSB on the edge the mode selects.
      if ((rising_mode && sclk_rise) || (!rising_mode && sclk_fall))
      begin
        sdo_nxt = shift_r[15];
      end
      if (cs_rise)
      begin
        case (cmd)
          `DSCC_CMD_NOP:
          begin
            shdn_nxt = shutdown;
          end
          `DSCC_CMD_LOAD_IN:
          begin
            input_nxt = sample;
          end
          `DSCC_CMD_LOAD_BOTH:
          begin
            input_nxt = sample;
            dac_nxt = sample;
            shdn_nxt = 1'b0;
          end
          `DSCC_CMD_UPDATE:
          begin
            dac_nxt = input_code;
            shdn_nxt = 1'b0;
          end
          `DSCC_CMD_UPO_LOW:
          begin
            upo_nxt = 1'b0;
          end
          // Refused silently while lockout is low; the master sees nothing.
          `DSCC_CMD_SHDN:
          begin
            if (pdl_s)
            begin
              shdn_nxt = 1'b1;
            end
          end
          `DSCC_CMD_UPO_HIGH:
          begin
            upo_nxt = 1'b1;
          end
          // Pattern 01 in the two top sample bits is undefined and keeps the mode.
          `DSCC_CMD_MODE:
          begin
            if (shift_r[`DSCC_MODE_BIT])
            begin
              mode_nxt = 1'b1;
            end
            else if (!shift_r[`DSCC_MODE0_BIT])
            begin
              mode_nxt = 1'b0;
            end
          end
          default:
          begin
            shdn_nxt = shutdown;
          end
        endcase
      end
      // The power-down pin acts on its rising edge, gated by the lockout input.
      if (pd_s && pdl_s && !pd_d_r)
      begin
        shdn_nxt = 1'b1;
      end
      if (shutdown && pdl_fall)
      begin
        shdn_nxt = 1'b0;
      end
      // Clear has the last word: reset code and out of shutdown.
      if (!clr_n_s)
      begin
        dac_nxt = reset_code;
        if (shutdown)
        begin
          upo_reset_pending_nxt = 1'b1;
        end
        shdn_nxt = 1'b0;
      end
      if (!shutdown && upo_reset_pending_r)
      begin
        upo_nxt = 1'b0;
        upo_reset_pending_nxt = 1'b0;
      end
      // A lockout input that is low refuses any shutdown entry above.
      if (!pdl_s && !shutdown)
      begin
        shdn_nxt = 1'b0;
      end
    end
  end

  // State registers; the power-up codes are caught on three clocks after reset release.
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      sclk_d_r <= 1'b0;
      cs_n_d_r <= 1'b1;
      pdl_d_r <= 1'b0;
      clr_n_d_r <= 1'b1;
      reset_value_select_d_r <= 1'b0;
      pd_d_r <= 1'b0;
      shift_r <= `DSCC_WORD_ZERO;
      input_code <= `DSCC_ZERO;
      dac_code <= `DSCC_ZERO;
      shutdown <= 1'b0;
      user_output_pin <= 1'b0;
      rising_mode <= 1'b0;
      serial_out <= 1'b0;
      upo_reset_pending_r <= 1'b0;
      init_cnt_r <= `DSCC_INIT_START;
      analog_out_en <= 1'b1;
    end
    else
    begin
      sclk_d_r <= sclk_s;
      cs_n_d_r <= cs_n_s;
      pdl_d_r <= pdl_s;
      clr_n_d_r <= clr_n_s;
      reset_value_select_d_r <= reset_value_select_s;
      pd_d_r <= pd_s;
      shift_r <= shift_nxt;
      input_code <= input_nxt;
      dac_code <= dac_nxt;
      shutdown <= shdn_nxt;
      user_output_pin <= upo_nxt;
      rising_mode <= mode_nxt;
      serial_out <= sdo_nxt;
      upo_reset_pending_r <= upo_reset_pending_nxt;
      if (init_busy)
      begin
        init_cnt_r <= init_cnt_r + 2'h1;
      end
      // The amplifier is released whenever shutdown ends; codes are kept.
      analog_out_en <= ~shdn_nxt;
    end
  end

endmodule

/* File: verification/dscc_assertions.sv */
// Port-level checks for the serial command control block.
`timescale 1ns/100ps
module dscc_assertions
(
  input wire core_clk,
  input wire rst,
  input wire chip_select_n,
  input wire shift_clk,
  input wire serial_in,
  input wire reset_value_select,
  input wire powerdown_lockout,
  input wire clear_n,
  input wire powerdown_pin,
  input wire serial_out,
  input wire user_output_pin,
  input wire [11:0] dac_code,
  input wire [11:0] input_code,
  input wire shutdown,
  input wire analog_out_en,
  input wire rising_mode
);
  logic cs_q;
  logic [3:0] age_r;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // Cycles since chip select rose; it saturates, so stale frames never excuse a change.
  always @(posedge core_clk)
  begin
    cs_q <= chip_select_n;
    if (rst)
      age_r <= 4'hf;
    else if (chip_select_n && !cs_q)
      age_r <= 4'h0;
    else if (age_r != 4'hf)
      age_r <= age_r + 4'h1;
  end
  sequence s_asleep_drop;
    (shutdown && clear_n && chip_select_n) ##1 $fell(powerdown_lockout);
  endsequence
  a_code_frame: assert property (
    $changed(input_code) && !$past(rst, 4) |-> age_r inside {[1:6]})
    else $error("input code moved off a frame end");
  a_mode_frame: assert property (
    $changed(rising_mode) |-> age_r inside {[1:6]})
    else $error("mode moved off a frame end");
  a_hiz_shdn: assert property (analog_out_en == !shutdown)
    else $error("output enable disagrees with shutdown");
  a_lock_refuse: assert property (
    (!powerdown_lockout)[*5] ##0 !shutdown |=> !shutdown)
    else $error("shutdown under lockout");
  a_clear_code: assert property (
    (!clear_n && $stable(reset_value_select))[*6] |->
    !shutdown && dac_code == (reset_value_select ? 12'h800 : 12'h000))
    else $error("clear code wrong");
  a_pd_no_wake: assert property (
    (powerdown_lockout && clear_n && chip_select_n)[*8] ##0 shutdown |=> shutdown)
    else $error("woke without cause");
  a_lock_wake: assert property (s_asleep_drop |-> ##[1:6] !shutdown)
    else $error("lockout fall did not wake");
  a_out_quiet: assert property ($stable(shift_clk)[*8] |=> $stable(serial_out))
    else $error("data out moved without shift edge");
endmodule

/* File: verification/dscc_master.sv */
// Serial master model that sends whole words on the three-wire link.
`timescale 1ns/100ps
module dscc_master
(
  input wire core_clk,
  output logic chip_select_n = 1'b1,
  output logic shift_clk = 1'b0,
  output logic serial_in = 1'b0
);
  // MSB first, data changed on falling edges, 160 ns period; clock idles low.
  task send(input logic [15:0] w);
    integer i;
    begin
      @(posedge core_clk) chip_select_n <= 1'b0;
      for (i = 15; i >= 0; i--)
      begin
        // Pause between the two bytes, chip select still low.
        if (i == 7)
          repeat (16) @(posedge core_clk);
        @(posedge core_clk) shift_clk <= 1'b0;
        serial_in <= w[i];
        repeat (8) @(posedge core_clk);
        shift_clk <= 1'b1;
        repeat (7) @(posedge core_clk);
      end
      @(posedge core_clk) shift_clk <= 1'b0;
      serial_in <= ~w[0];
      repeat (8) @(posedge core_clk);
      chip_select_n <= 1'b1;
      repeat (12) @(posedge core_clk);
    end
  endtask
endmodule

/* File: verification/tb_dac_serial_command_control.sv */
// Self-checking bench for the serial command control block.
`timescale 1ns/100ps
module tb_dac_serial_command_control;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic reset_value_select = 1'b1;
  logic powerdown_lockout = 1'b1;
  logic clear_n = 1'b1;
  logic powerdown_pin = 1'b0;
  wire chip_select_n, shift_clk, serial_in, serial_out, user_output_pin;
  wire shutdown, analog_out_en, rising_mode;
  wire [11:0] dac_code, input_code;
  logic [11:0] in_e, dac_e;
  logic shd_e, upo_e, mode_e, mode_was;
  integer bad_count = 0;
  integer compares = 0;
  integer i;
  dscc_top DUT (.*);
  dscc_master u_master (.*);
  // Core clock at 100 MHz.
  always #5 core_clk = ~core_clk;
  task chk(input logic [11:0] got, input logic [11:0] exp);
    begin
      compares++;
      if (got !== exp)
      begin
        bad_count++;
        $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task check_all;
    begin
      chk(dac_code, dac_e);
      chk(input_code, in_e);
      chk(12'(shutdown), 12'(shd_e));
      chk(12'(analog_out_en), 12'(!shd_e));
      chk(12'(user_output_pin), 12'(upo_e));
      chk(12'(rising_mode), 12'(mode_e));
    end
  endtask
  // Sends one word, predicts its effect, then compares everything.
  task frame(input logic [15:0] v);
    begin
      u_master.send(v);
      mode_was = mode_e;
      case (v[15:13])
        3'h1: in_e = v[12:1];
        3'h2:
        begin
          in_e = v[12:1];
          dac_e = v[12:1];
          shd_e = 1'b0;
        end
        3'h3:
        begin
          dac_e = in_e;
          shd_e = 1'b0;
        end
        3'h4: upo_e = 1'b0;
        3'h5: shd_e = shd_e | powerdown_lockout;
        3'h6: upo_e = 1'b1;
        3'h7: mode_e = v[12] | (mode_e & v[11]);
        default: ;
      endcase
      check_all;
      chk(12'(serial_out), 12'(mode_was ? 1'b0 : v[15]));
    end
  endtask
  task pins(input logic pd, input logic lk, input logic cl);
    begin
      @(posedge core_clk);
      powerdown_pin <= pd;
      powerdown_lockout <= lk;
      clear_n <= cl;
      repeat (10) @(posedge core_clk);
    end
  endtask
  task report_and_stop;
    begin
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // About fifty frames of some 300 cycles; two and a half times that means a hang.
  initial
  begin
    repeat (40000) @(posedge core_clk);
    bad_count++;
    report_and_stop;
  end
  // Reset, a random sweep over every command, then pin corner cases.
  initial
  begin
    void'($urandom(38111));
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    repeat (6) @(posedge core_clk);
    in_e = 12'h800;
    dac_e = 12'h800;
    shd_e = 1'b0;
    upo_e = 1'b0;
    mode_e = 1'b0;
    check_all;
    for (i = 0; i < 48; i++)
      frame({i[2:0], 12'($urandom), 1'b0});
    frame(16'h4ffe);
    pins(1'b0, 1'b0, 1'b1);
    frame(16'ha000);
    pins(1'b1, 1'b0, 1'b1);
    check_all;
    pins(1'b0, 1'b1, 1'b1);
    pins(1'b1, 1'b1, 1'b1);
    shd_e = 1'b1;
    check_all;
    pins(1'b0, 1'b1, 1'b1);
    frame(16'h2246);
    pins(1'b0, 1'b0, 1'b1);
    shd_e = 1'b0;
    check_all;
    pins(1'b0, 1'b1, 1'b1);
    frame(16'hc000);
    frame(16'ha000);
    @(posedge core_clk) reset_value_select <= 1'b0;
    pins(1'b0, 1'b1, 1'b0);
    dac_e = 12'h000;
    shd_e = 1'b0;
    upo_e = 1'b0;
    check_all;
    pins(1'b0, 1'b1, 1'b1);
    report_and_stop;
  end
endmodule
bind dscc_top dscc_assertions u_chk (.*);
